// [design/tmc_defines.svh]
// register offsets, field positions and reset values of the timer block
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH
// printed offsets 01h, 0Bh, 81h are not all multiples of four: kept as indices
`define TMC_IDX_COUNT    8'h01
`define TMC_IDX_INTCTL   8'h0b
`define TMC_IDX_OPTION   8'h81
`define TMC_IDX_CONTROL  8'h90
`define TMC_IDX_EVSTAT   8'h91
`define TMC_IDX_EVCLR    8'h92
`define TMC_IDX_EVEN     8'h93
`define TMC_OPT_RESET    8'hff
`define TMC_INTCTL_RESET 8'h00
`define TMC_OPT_SRC      5
`define TMC_OPT_EDGE     4
`define TMC_OPT_ASSIGN   3
`define TMC_INT_OVF_EN   5
`define TMC_INT_OVF_FLAG 2
`define TMC_INHIBIT_CYC  2'h2
`endif

// [design/tmc_pkg.sv]
// types of the timer block
package tmc_pkg;
  typedef logic [7:0] tmc_byte_t;
  typedef enum logic [2:0] {
    TMC_IDLE  = 3'b001,
    TMC_SETUP = 3'b010,
    TMC_ACC   = 3'b100
  } tmc_apb_e;
endpackage

// [design/tmc_timer.sv]
// eight-bit timer/counter with shared divider and apb registers
//
// The APB register port is this design's own decision.
`include "tmc_defines.svh"
module tmc_timer (
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  input  wire logic          external_count_pin,
  input  wire logic          sleep_mode,
  input  wire logic          watchdog_clear_instruction,
  output logic               watchdog_tick,
  output logic               overflow_irq,
  output logic               event_irq
);
  import tmc_pkg::*;

  tmc_byte_t   timer_count_value_q;
  tmc_byte_t   option_settings_q;
  logic        overflow_flag_q;
  logic        overflow_irq_enable_q;
  logic [5:0]  intctl_other_q;
  logic [7:0]  divider_q;
  logic [1:0]  inhibit_q;
  logic        pin_s1_q, pin_s2_q, pin_d1_q, pin_d2_q, pin_d3_q;
  logic        ev_stat_q, ev_en_q, sleep_stop_q;
  logic        source_select_bit, edge_select_bit, divider_assign_bit;
  logic [2:0]  divider_ratio_field;
  logic        wr_acc, rd_acc, hit, wr_count, base_tick, div_tick, cnt_tick, wrap;
  logic [7:0]  idx;
  logic [31:0] rdata_d;

  assign source_select_bit   = option_settings_q[`TMC_OPT_SRC];
  assign edge_select_bit     = option_settings_q[`TMC_OPT_EDGE];
  assign divider_assign_bit  = option_settings_q[`TMC_OPT_ASSIGN];
  assign divider_ratio_field = option_settings_q[2:0];

  // apb decode, zero wait states
  assign idx     = paddr[9:2];
  assign hit     = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h0) &&
                   (idx == `TMC_IDX_COUNT || idx == `TMC_IDX_INTCTL ||
                    idx == `TMC_IDX_OPTION || idx == `TMC_IDX_CONTROL ||
                    idx == `TMC_IDX_EVSTAT || idx == `TMC_IDX_EVCLR ||
                    idx == `TMC_IDX_EVEN);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign wr_acc  = psel && penable && pwrite && hit && pstrb[0];
  assign rd_acc  = psel && penable && !pwrite && hit;
  assign wr_count = wr_acc && idx == `TMC_IDX_COUNT;

  // pin sync, first stage read only by second
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= external_count_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pin_d1_q <= 1'b0;
      pin_d2_q <= 1'b0;
      pin_d3_q <= 1'b0;
    end else begin
      pin_d1_q <= pin_s2_q;
      pin_d2_q <= pin_d1_q;
      pin_d3_q <= pin_d2_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) sleep_stop_q <= 1'b0;
    else sleep_stop_q <= sleep_mode;
  end

  always_comb begin
    if (source_select_bit)
      base_tick = edge_select_bit ? (pin_d3_q && !pin_d2_q) : (!pin_d3_q && pin_d2_q);
    else
      base_tick = 1'b1;
    if (sleep_stop_q)
      base_tick = 1'b0;
  end

  always_comb begin
    if (divider_assign_bit) begin
      div_tick = (divider_ratio_field == 3'h0) ? 1'b1 :
                 (divider_q[divider_ratio_field - 3'h1 +: 1] == 1'b1) &&
                 ((divider_q & ((8'h01 << (divider_ratio_field - 3'h1)) - 8'h01)) ==
                  ((8'h01 << (divider_ratio_field - 3'h1)) - 8'h01));
      cnt_tick = base_tick;
    end else begin
      div_tick = ((divider_q | ~((8'h02 << divider_ratio_field) - 8'h01)) == 8'hff);
      cnt_tick = base_tick && div_tick;
    end
  end

  // divider has no bus access; clears
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      divider_q <= 8'h00;
    end else if ((!divider_assign_bit && wr_count) ||
                 (divider_assign_bit && watchdog_clear_instruction)) begin
      divider_q <= 8'h00;
    end else if (!divider_assign_bit && base_tick) begin
      divider_q <= divider_q + 8'h01;
    end else if (divider_assign_bit && !sleep_stop_q) begin
      divider_q <= divider_q + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) watchdog_tick <= 1'b0;
    else watchdog_tick <= divider_assign_bit && !sleep_stop_q &&
                          !watchdog_clear_instruction && div_tick;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) inhibit_q <= 2'h0;
    else if (wr_count) inhibit_q <= `TMC_INHIBIT_CYC;
    else if (inhibit_q != 2'h0) inhibit_q <= inhibit_q - 2'h1;
  end

  assign wrap = cnt_tick && inhibit_q == 2'h0 && !wr_count &&
                timer_count_value_q == 8'hff;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) timer_count_value_q <= 8'h00;
    else if (wr_count) timer_count_value_q <= pwdata[7:0];
    else if (cnt_tick && inhibit_q == 2'h0)
      timer_count_value_q <= timer_count_value_q + 8'h01;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) option_settings_q <= `TMC_OPT_RESET;
    else if (wr_acc && idx == `TMC_IDX_OPTION) option_settings_q <= pwdata[7:0];
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      overflow_flag_q       <= 1'b0;
      overflow_irq_enable_q <= 1'b0;
      intctl_other_q        <= 6'h00;
    end else begin
      if (wrap) overflow_flag_q <= 1'b1;
      else if (wr_acc && idx == `TMC_IDX_INTCTL)
        overflow_flag_q <= pwdata[`TMC_INT_OVF_FLAG];
      if (wr_acc && idx == `TMC_IDX_INTCTL) begin
        overflow_irq_enable_q <= pwdata[`TMC_INT_OVF_EN];
        intctl_other_q <= {pwdata[7:6], pwdata[4:3], pwdata[1:0]};
      end
    end
  end

  // event status, clear and enable registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ev_stat_q <= 1'b0;
      ev_en_q   <= 1'b0;
    end else begin
      if (wrap) ev_stat_q <= 1'b1;
      else if (wr_acc && idx == `TMC_IDX_EVCLR && pwdata[0]) ev_stat_q <= 1'b0;
      if (wr_acc && idx == `TMC_IDX_EVEN) ev_en_q <= pwdata[0];
    end
  end

  assign overflow_irq = overflow_flag_q && overflow_irq_enable_q;
  assign event_irq    = ev_stat_q && ev_en_q;

  always_comb begin
    rdata_d = 32'h0;
    case (idx)
      `TMC_IDX_COUNT:   rdata_d[7:0] = timer_count_value_q;
      `TMC_IDX_INTCTL:  rdata_d[7:0] = {intctl_other_q[5:4], overflow_irq_enable_q,
                                        intctl_other_q[3:2], overflow_flag_q,
                                        intctl_other_q[1:0]};
      `TMC_IDX_OPTION:  rdata_d[7:0] = option_settings_q;
      `TMC_IDX_CONTROL: rdata_d[1:0] = {sleep_stop_q, inhibit_q != 2'h0};
      `TMC_IDX_EVSTAT:  rdata_d[0]   = ev_stat_q;
      `TMC_IDX_EVEN:    rdata_d[0]   = ev_en_q;
      default:          rdata_d      = 32'h0;
    endcase
  end

  assign prdata = rd_acc ? rdata_d : 32'h0;

  chk_wrap_sets_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wrap |=> overflow_flag_q) else $error("wrap did not set flag");
  chk_write_inhibit: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_count |=> ##1 (timer_count_value_q == $past(timer_count_value_q))
    ) else $error("count moved during inhibit");
  chk_irq_masked: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !overflow_irq_enable_q |-> !overflow_irq) else $error("irq not masked");
  chk_flag_sticky: assert property (@(posedge ref_clk) disable iff (!reset_n)
    overflow_flag_q && !(wr_acc && idx == `TMC_IDX_INTCTL) |=> overflow_flag_q
    ) else $error("flag dropped");
  chk_sleep_stop: assert property (@(posedge ref_clk) disable iff (!reset_n)
    sleep_stop_q && !wr_count |=> $stable(timer_count_value_q)
    ) else $error("counted in sleep");
  chk_div_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_count && !divider_assign_bit |=> divider_q == 8'h00) else $error("div kept");
  chk_wdt_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    watchdog_clear_instruction && divider_assign_bit |=> divider_q == 8'h00
    ) else $error("div not cleared by watchdog clear");
  chk_timer_mode: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !source_select_bit && divider_assign_bit && !sleep_stop_q && inhibit_q == 2'h0 &&
    !wr_count |=> timer_count_value_q == $past(timer_count_value_q) + 8'h01
    ) else $error("timer mode missed a count");
  // divider gates count only when assigned to the timer
  chk_div_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !divider_assign_bit && !div_tick |-> !cnt_tick) else $error("ungated count");

  chk_ext_edge_count: assert property (
    @(posedge ref_clk) disable iff (!reset_n) source_select_bit && divider_assign_bit &&
    inhibit_q == 2'h0 && !wr_count && base_tick |=>
    timer_count_value_q == $past(timer_count_value_q) + 8'h01) else $error("edge lost");

  chk_ext_no_edge: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    source_select_bit && !base_tick && !wr_count |=> $stable(timer_count_value_q)
  ) else $error("count without edge");

  chk_rise_detect: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !sleep_stop_q && source_select_bit && !edge_select_bit && pin_d2_q && !pin_d3_q |-> base_tick
  ) else $error("rising edge missed");

  chk_fall_detect: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !sleep_stop_q && source_select_bit && edge_select_bit && !pin_d2_q && pin_d3_q |-> base_tick
  ) else $error("falling edge missed");

  chk_sync_chain: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    1'b1 |-> pin_d3_q == $past(pin_s2_q, 3)
  ) else $error("chain delay wrong");

  chk_sync_stage: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    1'b1 |-> pin_s2_q == $past(pin_s1_q)
  ) else $error("sync stage wrong");

  // watchdog idle while timer owns divider
  chk_wdt_no_tick: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !divider_assign_bit |=> !watchdog_tick
  ) else $error("watchdog ticked without divider");

  chk_div_sleep: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    sleep_stop_q && !divider_assign_bit && !wr_count |=> $stable(divider_q)
  ) else $error("divider ran in sleep");

  chk_irq_level: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    overflow_flag_q && overflow_irq_enable_q |-> overflow_irq
  ) else $error("enabled irq missing");

  chk_assign_kept: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    wr_count |=> $stable(divider_assign_bit)
  ) else $error("assignment changed");

  chk_ratio_tap: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !divider_assign_bit && divider_ratio_field == 3'h0 |-> div_tick == divider_q[0]
  ) else $error("1:2 tap wrong");

  chk_wdt_ratio_one: assert property (
    @(posedge ref_clk) disable iff (!reset_n) divider_assign_bit &&
    divider_ratio_field == 3'h0 && !sleep_stop_q && !watchdog_clear_instruction |=> watchdog_tick
  ) else $error("1:1 watchdog tick missing");

  chk_event_sticky: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    ev_stat_q && !(wr_acc && idx == `TMC_IDX_EVCLR) |=> ev_stat_q
  ) else $error("event status dropped");

  chk_no_wrap_sleep: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    sleep_stop_q |-> !wrap
  ) else $error("wrap in sleep");

  chk_event_irq: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    ev_stat_q && ev_en_q |-> event_irq
  ) else $error("event irq missing");

  chk_count_write: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    wr_count |=> timer_count_value_q == $past(pwdata[7:0])
  ) else $error("count write lost");
endmodule

// [test/tb_top.sv]
// self-checking bench of the timer block
`include "tmc_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tmc_pkg::*;
  localparam logic [31:0] A_CNT = {22'h0, `TMC_IDX_COUNT, 2'b00};
  localparam logic [31:0] A_INT = {22'h0, `TMC_IDX_INTCTL, 2'b00};
  localparam logic [31:0] A_OPT = {22'h0, `TMC_IDX_OPTION, 2'b00};
  localparam logic [31:0] A_CLR = {22'h0, `TMC_IDX_EVCLR, 2'b00};
  localparam logic [31:0] A_EN  = {22'h0, `TMC_IDX_EVEN, 2'b00};
  logic        ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic        flip, ext_pin, sleep_mode, wd_clr, wd_tick, ovf_irq, ev_irq, tick_seen;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb;
  tmc_byte_t   base;
  int          errors, total_checks, cycles;

  tmc_timer tmc_timer_inst (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .external_count_pin(ext_pin),
    .sleep_mode(sleep_mode), .watchdog_clear_instruction(wd_clr),
    .watchdog_tick(wd_tick), .overflow_irq(ovf_irq), .event_irq(ev_irq));
  tmc_pin_model tmc_pin_model_inst (.ref_clk(ref_clk), .reset_n(reset_n), .flip(flip),
    .count_pin(ext_pin));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (wd_tick === 1'b1)
      tick_seen <= 1'b1;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      errors++;
  endtask
  task automatic reg_chk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic pulse_flip();
    @(posedge ref_clk);
    flip <= 1'b1;
    @(posedge ref_clk);
    flip <= 1'b0;
  endtask

  task automatic t_reset();
    reg_chk(A_OPT, 32'hff); // reset value
    reg_chk(A_INT, 32'h00); // reset value
    reg_chk(A_CNT, 32'h00); // idle pin
    apb(1'b0, 32'h3fc, 32'h0);
    check(err, 1'b1); // no hidden address
    check(rd, 32'h0); // reads zero
    apb(1'b1, 32'h006, 32'h55);
    check(err, 1'b1); // misaligned
  endtask
  task automatic t_inhibit();
    apb(1'b1, A_OPT, 32'h08);
    apb(1'b1, A_CNT, 32'h40);
    reg_chk(A_CNT, 32'h40); // two held cycles
    reg_chk(A_CNT, 32'h43); // one per cycle
  endtask
  task automatic t_ratio();
    apb(1'b1, A_OPT, 32'h0);
    repeat (2) @(posedge ref_clk);
    tick_seen <= 1'b0;
    for (int r = 0; r < 8; r++) begin
      apb(1'b1, A_OPT, r);
      apb(1'b0, A_CNT, 32'h0);
      base = rd[7:0];
      repeat ((4 << r) - 3) @(posedge ref_clk);
      apb(1'b0, A_CNT, 32'h0);
      check(rd[7:0] - base, 8'h02); // divide by two to 256
    end
    check(tick_seen, 1'b0); // watchdog gets nothing
    // safe move of divider to watchdog
    apb(1'b1, A_CNT, 32'h0);
    wd_clr <= 1'b1;
    @(posedge ref_clk);
    wd_clr <= 1'b0;
    apb(1'b1, A_OPT, 32'h08);
    reg_chk(A_OPT, 32'h08); // reassigned on the fly
    check(tick_seen, 1'b1); // watchdog ticks at 1:1
  endtask
  task automatic t_ext();
    apb(1'b1, A_OPT, 32'h28);
    apb(1'b1, A_CNT, 32'h0);
    base = 8'h00;
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, A_OPT, e ? 32'h38 : 32'h28);
      pulse_flip();
      reg_chk(A_CNT, base); // increment not yet landed
      repeat (10) @(posedge ref_clk);
      base = base + ((e == 0) ? 8'h01 : 8'h00);
      reg_chk(A_CNT, base); // rising edge counted in rising mode only
      pulse_flip();
      repeat (10) @(posedge ref_clk);
      base = base + ((e == 1) ? 8'h01 : 8'h00);
      reg_chk(A_CNT, base); // falling edge counted in falling mode only
    end
    apb(1'b1, A_OPT, 32'h28);
    sleep_mode <= 1'b1;
    pulse_flip();
    repeat (10) @(posedge ref_clk);
    reg_chk(A_CNT, base); // halted in sleep
    sleep_mode <= 1'b0;
    pulse_flip();
    repeat (10) @(posedge ref_clk);
    reg_chk(A_CNT, base); // falling edge after sleep not counted in rising mode
  endtask
  task automatic t_ovf();
    apb(1'b1, A_CNT, 32'hff);
    apb(1'b1, A_INT, 32'h20);
    apb(1'b1, A_EN, 32'h1);
    apb(1'b1, A_OPT, 32'h08);
    repeat (8) @(posedge ref_clk);
    apb(1'b1, A_OPT, 32'h28);
    reg_chk(A_INT, 32'h24); // flag on wrap
    @(negedge ref_clk);
    check(ovf_irq, 1'b1); // enabled request
    check(ev_irq, 1'b1); // event raised
    apb(1'b1, A_INT, 32'h04);
    @(negedge ref_clk);
    check(ovf_irq, 1'b0); // masked
    repeat (20) @(posedge ref_clk);
    reg_chk(A_INT, 32'h04); // flag sticky
    apb(1'b1, A_CLR, 32'h1);
    @(negedge ref_clk);
    check(ev_irq, 1'b0); // event cleared
    apb(1'b1, A_INT, 32'h00);
    reg_chk(A_INT, 32'h00); // software clear
  endtask

  initial begin
    {psel, penable, pwrite, flip, sleep_mode, wd_clr, tick_seen} = '0;
    {paddr, pwdata} = '0;
    pstrb = 4'hf;
    reset_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset();
    t_inhibit();
    t_ratio();
    t_ext();
    t_ovf();
    finish_test();
  end
endmodule

// [test/tmc_pin_model.sv]
// far-side driver of the external count pin
module tmc_pin_model (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic flip,
  output logic      count_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // level held between flips, long enough to synchronize
  always_ff @(posedge ref_clk) begin
    if (!reset_n)
      count_pin <= 1'b0;
    else if (flip)
      count_pin <= ~count_pin;
  end
endmodule
